// ### core/scr_adc_clk_div.sv
// ADC clock generator dividing the reference tick stream by 4*div+2
`timescale 1ns/1ps
module scr_adc_clk_div
    import scr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       enable,
    input  wire logic       ref_tick,
    input  wire logic [7:0] div,
    output logic            adc_clk_ff,
    output logic            adc_tick_ff
);
    // Half period in reference ticks is (4*div+2)/2 = 2*div+1
    localparam logic [9:0] HALF_MUL = 10'((ADC_DIV_MUL) / 2);
    localparam logic [9:0] HALF_ADD = 10'((ADC_DIV_ADD) / 2);

    logic [9:0] cnt_ff;
    logic [9:0] half_len;

    assign half_len = HALF_MUL * {2'b00, div} + HALF_ADD;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff      <= 10'h000;
            adc_clk_ff  <= 1'b0;
            adc_tick_ff <= 1'b0;
        end else if (ce) begin
            adc_tick_ff <= 1'b0;
            if (!enable) begin
                cnt_ff     <= 10'h000;
                adc_clk_ff <= 1'b0;
            end else if (ref_tick) begin
                if (cnt_ff == half_len - 10'h001) begin // [RULE_02]
                    cnt_ff      <= 10'h000;
                    adc_clk_ff  <= ~adc_clk_ff;
                    adc_tick_ff <= ~adc_clk_ff;
                end else begin
                    cnt_ff <= cnt_ff + 10'h001;
                end
            end
        end
    end
endmodule // scr_adc_clk_div

// ### core/scr_pkg.sv
// Constants for the calibration and ADC configuration register slice
package scr_pkg;
    localparam int          SCR_ADDR_W      = 12;
    localparam int          SCR_REG_NUM     = 18;
    localparam logic [7:0]  SCR_RESET_VAL   = 8'h00;
    localparam logic [11:0] SCR_OFFS [0:SCR_REG_NUM-1] = '{
        12'h036, 12'h037, 12'h038, 12'h039, 12'h03a, 12'h03b,
        12'h03c, 12'h03d, 12'h03e, 12'h03f, 12'h040, 12'h041,
        12'h042, 12'h043, 12'h044, 12'h045, 12'h04b, 12'h04c};
    localparam logic [11:0] SCR_STATUS_OFFS = 12'h058;
    // Register indices into the storage array
    localparam int IDX_DIV_BUF_LUT   = 0;
    localparam int IDX_DECISION_TO   = 1;
    localparam int IDX_TUNE_TO_LOW   = 2;
    localparam int IDX_TUNE_TO_HIGH  = 3;
    localparam int IDX_BAND_TO_LOW   = 4;
    localparam int IDX_BAND_TO_HIGH  = 5;
    localparam int IDX_LOGIC_LEVEL   = 7;
    localparam int IDX_ADC_DIV       = 8;
    localparam int IDX_ADC_EN        = 9;
    localparam int IDX_RF_MUTE       = 10;
    // Field positions
    localparam int BIT_OUT_DIV_DBUF  = 7;
    localparam int BIT_DCLK_DBUF     = 6;
    localparam int BIT_TABLE_GEN     = 1;
    localparam int BIT_TABLE_CAL     = 0;
    localparam int BIT_OSC_DBUF      = 7;
    localparam int BIT_DELAY_DBUF    = 7;
    localparam int BIT_LEVEL_SEL     = 5;
    localparam int BIT_CONV_EN       = 7;
    localparam int BIT_ADC_EN        = 1;
    localparam int MUTE_ONE_LSB      = 0;
    localparam int MUTE_TWO_LSB      = 3;
    localparam int MUTE_W            = 3;
    localparam int TIMEOUT_HIGH_W    = 7;
    localparam int BIT_STAT_TBL_BUSY = 7;
    localparam int BIT_STAT_CAL_BUSY = 1;
    // ADC clock divide ratio is ADC_DIV_MUL * div + ADC_DIV_ADD
    localparam int ADC_DIV_MUL       = 4;
    localparam int ADC_DIV_ADD       = 2;
    localparam int CAL_SEARCH_STEPS  = 8;
    localparam int CAL_TABLE_STEPS   = 1;

    typedef enum logic [2:0] {
        SCR_CAL_IDLE   = 3'b000,
        SCR_CAL_TUNE   = 3'b001,
        SCR_CAL_BAND   = 3'b010,
        SCR_CAL_DECIDE = 3'b011
    } scr_cal_state_t;
endpackage

// ### core/scr_regs.sv
// Calibration, ADC and output mute configuration register slice
//
// Contract
// (RULE_01) All registers reset to zero
// (RULE_02) ADC clock is reference over 4*div+2
// (RULE_03) Tune settle timeout from 0x038 and 0x039[6:0]
// (RULE_04) Band settle timeout from 0x03A and 0x03B[6:0]
// (RULE_05) Eight-bit timeout per calibration decision step
// (RULE_06) 0x039 bit 7 double-buffers manual oscillator values
// (RULE_07) 0x036 bits 6/7 double-buffer clock/output dividers
// (RULE_08) 0x036 bit 1 enables table generation
// (RULE_09) 0x036 bit 0 calibrates from table
// (RULE_10) 0x040 bits 2:0 mute output one
// (RULE_11) 0x040 bits 5:3 mute output two
// (RULE_12) Buffered values apply only at update event
// (RULE_13) Busy status high while calibration runs
`timescale 1ns/1ps
module scr_regs
    import scr_pkg::*;
#(
    parameter int OUT_DIV_W    = 2,
    parameter int CLK_DIV_W    = 8,
    parameter int CORE_W       = 2,
    parameter int BAND_W       = 8,
    parameter int BIAS_W       = 6,
    parameter int DELAY_W      = 8,
    parameter int SEARCH_STEPS = CAL_SEARCH_STEPS
)(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic [SCR_ADDR_W-1:0] reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata_ff,
    input  wire logic                  dbuf_update,
    input  wire logic [OUT_DIV_W-1:0]  rf_output_divider,
    input  wire logic [CLK_DIV_W-1:0]  digital_ref_clk_divider,
    input  wire logic [CLK_DIV_W-1:0]  digital_fb_clk_divider,
    input  wire logic [CORE_W-1:0]     manual_osc_core,
    input  wire logic [BAND_W-1:0]     manual_osc_band,
    input  wire logic [BIAS_W-1:0]     manual_osc_bias,
    input  wire logic [DELAY_W-1:0]    delay_ctrl,
    output logic [OUT_DIV_W-1:0]       rf_output_divider_ff,
    output logic [CLK_DIV_W-1:0]       digital_ref_clk_divider_ff,
    output logic [CLK_DIV_W-1:0]       digital_fb_clk_divider_ff,
    output logic [CORE_W-1:0]          manual_osc_core_ff,
    output logic [BAND_W-1:0]          manual_osc_band_ff,
    output logic [BIAS_W-1:0]          manual_osc_bias_ff,
    output logic [DELAY_W-1:0]         delay_ctrl_ff,
    input  wire logic                  ref_tick,
    input  wire logic                  cal_start,
    output logic                       calibration_busy,
    output logic                       table_generate_active,
    output logic                       table_lookup_mode,
    output logic                       cal_decide_ff,
    output logic                       cal_done_ff,
    output logic [2:0]                 output_one_mute,
    output logic [2:0]                 output_two_mute,
    output logic                       logic_level_high,
    output logic                       conversion_enable,
    output logic                       adc_clk,
    output logic                       adc_tick
);
    logic                 rst_meta_ff;
    logic                 rst_sync_ff;
    logic [7:0]           regs_ff [0:SCR_REG_NUM-1];
    logic [SCR_REG_NUM-1:0] hit;
    logic                 any_hit;
    logic [7:0]           rd_mux;
    logic [7:0]           status_byte;

    // Reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Byte storage, one flop group per register
    genvar gi;
    generate
        for (gi = 0; gi < SCR_REG_NUM; gi++) begin : g_reg
            assign hit[gi] = (reg_addr == SCR_OFFS[gi]);
            always_ff @(posedge clk or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    regs_ff[gi] <= SCR_RESET_VAL; // [RULE_01]
                end else if (ce && reg_wr && hit[gi]) begin
                    regs_ff[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    assign any_hit = |hit;

    // Read mux over the storage plus the status byte
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < SCR_REG_NUM; i++) begin
            if (hit[i]) begin
                rd_mux = regs_ff[i];
            end
        end
        if (!any_hit && reg_addr == SCR_STATUS_OFFS) begin
            rd_mux = status_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            reg_rdata_ff <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata_ff <= rd_mux;
        end
    end

    // Field decode
    logic                 out_div_dbuf_sel;
    logic                 digital_clk_div_dbuf_sel;
    logic                 manual_osc_dbuf_sel;
    logic                 delay_ctrl_dbuf_sel;
    logic                 table_generate_enable;
    logic                 table_calibrate_enable;
    logic [7:0]           decision_timeout;
    logic [14:0]          tune_settle_timeout;
    logic [14:0]          band_core_settle_timeout;

    assign out_div_dbuf_sel         = regs_ff[IDX_DIV_BUF_LUT][BIT_OUT_DIV_DBUF]; // [RULE_07]
    assign digital_clk_div_dbuf_sel = regs_ff[IDX_DIV_BUF_LUT][BIT_DCLK_DBUF];    // [RULE_07]
    assign table_generate_enable    = regs_ff[IDX_DIV_BUF_LUT][BIT_TABLE_GEN];    // [RULE_08]
    assign table_calibrate_enable   = regs_ff[IDX_DIV_BUF_LUT][BIT_TABLE_CAL];    // [RULE_09]
    assign manual_osc_dbuf_sel      = regs_ff[IDX_TUNE_TO_HIGH][BIT_OSC_DBUF];    // [RULE_06]
    assign delay_ctrl_dbuf_sel      = regs_ff[IDX_BAND_TO_HIGH][BIT_DELAY_DBUF];
    assign decision_timeout         = regs_ff[IDX_DECISION_TO];                   // [RULE_05]
    assign tune_settle_timeout      = {regs_ff[IDX_TUNE_TO_HIGH][TIMEOUT_HIGH_W-1:0],
                                       regs_ff[IDX_TUNE_TO_LOW]};                 // [RULE_03]
    assign band_core_settle_timeout = {regs_ff[IDX_BAND_TO_HIGH][TIMEOUT_HIGH_W-1:0],
                                       regs_ff[IDX_BAND_TO_LOW]};                 // [RULE_04]

    assign output_one_mute   = regs_ff[IDX_RF_MUTE][MUTE_ONE_LSB +: MUTE_W]; // [RULE_10]
    assign output_two_mute   = regs_ff[IDX_RF_MUTE][MUTE_TWO_LSB +: MUTE_W]; // [RULE_11]
    assign logic_level_high  = regs_ff[IDX_LOGIC_LEVEL][BIT_LEVEL_SEL];
    assign conversion_enable = regs_ff[IDX_ADC_EN][BIT_CONV_EN];

    // Applied stages: follow directly when unbuffered, else load on update
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rf_output_divider_ff <= '0;
        end else if (ce && (!out_div_dbuf_sel || dbuf_update)) begin // [RULE_07] [RULE_12]
            rf_output_divider_ff <= rf_output_divider;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            digital_ref_clk_divider_ff <= '0;
            digital_fb_clk_divider_ff  <= '0;
        end else if (ce && (!digital_clk_div_dbuf_sel || dbuf_update)) begin // [RULE_12]
            digital_ref_clk_divider_ff <= digital_ref_clk_divider;
            digital_fb_clk_divider_ff  <= digital_fb_clk_divider;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            manual_osc_core_ff <= '0;
            manual_osc_band_ff <= '0;
            manual_osc_bias_ff <= '0;
        end else if (ce && (!manual_osc_dbuf_sel || dbuf_update)) begin // [RULE_06] [RULE_12]
            manual_osc_core_ff <= manual_osc_core;
            manual_osc_band_ff <= manual_osc_band;
            manual_osc_bias_ff <= manual_osc_bias;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            delay_ctrl_ff <= '0;
        end else if (ce && (!delay_ctrl_dbuf_sel || dbuf_update)) begin // [RULE_12]
            delay_ctrl_ff <= delay_ctrl;
        end
    end

    // Calibration timing sequencer, counted in reference ticks
    scr_cal_state_t state_ff;
    scr_cal_state_t nxt_state;
    logic [14:0]    cnt_ff;
    logic [3:0]     step_ff;
    logic [3:0]     last_step;
    logic           use_table_ff;
    logic           phase_end;
    logic [14:0]    phase_limit;

    always_comb begin
        case (state_ff)
            SCR_CAL_TUNE:   phase_limit = tune_settle_timeout;
            SCR_CAL_BAND:   phase_limit = band_core_settle_timeout;
            SCR_CAL_DECIDE: phase_limit = {7'h00, decision_timeout}; // [RULE_05]
            default:        phase_limit = 15'h0000;
        endcase
    end

    assign phase_end = ref_tick && (cnt_ff >= phase_limit);
    assign last_step = use_table_ff ? 4'(CAL_TABLE_STEPS - 1) : 4'(SEARCH_STEPS - 1); // [RULE_09]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCR_CAL_IDLE: begin
                if (cal_start) begin
                    nxt_state = SCR_CAL_TUNE;
                end
            end
            SCR_CAL_TUNE: begin
                if (phase_end) begin
                    nxt_state = SCR_CAL_BAND;
                end
            end
            SCR_CAL_BAND: begin
                if (phase_end) begin
                    nxt_state = SCR_CAL_DECIDE;
                end
            end
            SCR_CAL_DECIDE: begin
                if (phase_end && step_ff == last_step) begin
                    nxt_state = SCR_CAL_IDLE;
                end
            end
            default: nxt_state = SCR_CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= SCR_CAL_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cnt_ff <= 15'h0000;
        end else if (ce) begin
            if (nxt_state != state_ff || state_ff == SCR_CAL_IDLE || phase_end) begin
                cnt_ff <= 15'h0000;
            end else if (ref_tick) begin
                cnt_ff <= cnt_ff + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            step_ff      <= 4'h0;
            use_table_ff <= 1'b0;
        end else if (ce) begin
            if (state_ff == SCR_CAL_IDLE && cal_start) begin
                step_ff      <= 4'h0;
                use_table_ff <= table_calibrate_enable; // [RULE_09]
            end else if (state_ff == SCR_CAL_DECIDE && phase_end) begin
                step_ff <= step_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cal_decide_ff <= 1'b0;
            cal_done_ff   <= 1'b0;
        end else if (ce) begin
            cal_decide_ff <= (state_ff == SCR_CAL_DECIDE) && phase_end;
            cal_done_ff   <= (state_ff == SCR_CAL_DECIDE) && phase_end && (step_ff == last_step);
        end
    end

    assign calibration_busy      = (state_ff != SCR_CAL_IDLE);                    // [RULE_13]
    assign table_generate_active = calibration_busy && table_generate_enable;     // [RULE_08]
    assign table_lookup_mode     = calibration_busy && use_table_ff;

    always_comb begin
        status_byte                    = 8'h00;
        status_byte[BIT_STAT_TBL_BUSY] = table_generate_active;
        status_byte[BIT_STAT_CAL_BUSY] = calibration_busy; // [RULE_13]
    end

    // ADC clock from the reference tick stream
    scr_adc_clk_div u_adc_div (
        .clk        (clk),
        .rst_n      (rst_sync_ff),
        .ce         (ce),
        .enable     (regs_ff[IDX_ADC_EN][BIT_ADC_EN]),
        .ref_tick   (ref_tick),
        .div        (regs_ff[IDX_ADC_DIV]), // [RULE_02]
        .adc_clk_ff (adc_clk),
        .adc_tick_ff(adc_tick)
    );
endmodule // scr_regs

// ### dv/scr_regs_chk.sv
// Assertion checker for the configuration register slice
`timescale 1ns/1ps
module scr_regs_chk
    import scr_pkg::*;
#(
    parameter int BAND_W = 8
)(
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  ce,
    input wire logic [SCR_ADDR_W-1:0] reg_addr,
    input wire logic                  reg_wr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  dbuf_update,
    input wire logic [BAND_W-1:0]     manual_osc_band,
    input wire logic [BAND_W-1:0]     manual_osc_band_ff,
    input wire logic                  cal_start,
    input wire logic                  calibration_busy,
    input wire logic                  table_generate_active,
    input wire logic                  cal_done_ff,
    input wire logic [2:0]            output_one_mute,
    input wire logic [2:0]            output_two_mute
);
    logic       osc_dbuf_ff;
    logic       gen_en_ff;
    wire        wr_mute = ce && reg_wr && reg_addr == 12'h040;
    wire  [2:0] wd_lo   = reg_wdata[2:0];
    wire  [2:0] wd_mid  = reg_wdata[5:3];

    // Mirrors of the oscillator buffering select and the table generation enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_dbuf_ff <= 1'b0;
            gen_en_ff   <= 1'b0;
        end else if (ce && reg_wr) begin
            if (reg_addr == 12'h039) begin
                osc_dbuf_ff <= reg_wdata[7];
            end
            if (reg_addr == 12'h036) begin
                gen_en_ff <= reg_wdata[1];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_mute_one_write:
        assert property (wr_mute |=> output_one_mute == $past(wd_lo))
        else $error("output one mute does not follow write");
    a_mute_two_write:
        assert property (wr_mute |=> output_two_mute == $past(wd_mid))
        else $error("output two mute does not follow write");
    a_mute_hold:
        assert property (!wr_mute |=> $stable(output_one_mute) && $stable(output_two_mute))
        else $error("mute fields changed without write");
    a_busy_start:
        assert property (ce && cal_start && !calibration_busy |=> calibration_busy)
        else $error("busy not raised after start");
    a_busy_end_done:
        assert property ($fell(calibration_busy) |-> cal_done_ff)
        else $error("busy dropped without done pulse");
    a_gen_in_busy:
        assert property (table_generate_active == (calibration_busy && gen_en_ff))
        else $error("table generation flag differs from busy and enable");
    a_osc_hold:
        assert property (ce && osc_dbuf_ff && !dbuf_update |=> $stable(manual_osc_band_ff))
        else $error("buffered band changed without update");
    a_osc_update:
        assert property (ce && osc_dbuf_ff && dbuf_update |=>
                         manual_osc_band_ff == $past(manual_osc_band))
        else $error("buffered band not loaded on update");
    a_osc_direct:
        assert property (ce && !osc_dbuf_ff |=> manual_osc_band_ff == $past(manual_osc_band))
        else $error("unbuffered band does not follow raw value");

    c_cal_done: cover property (cal_done_ff);
    c_gen_busy: cover property (table_generate_active);
    c_osc_update: cover property (osc_dbuf_ff && dbuf_update);
endmodule // scr_regs_chk

bind scr_regs scr_regs_chk #(.BAND_W(BAND_W)) u_chk (
    .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .dbuf_update(dbuf_update), .manual_osc_band(manual_osc_band),
    .manual_osc_band_ff(manual_osc_band_ff), .cal_start(cal_start),
    .calibration_busy(calibration_busy), .table_generate_active(table_generate_active),
    .cal_done_ff(cal_done_ff), .output_one_mute(output_one_mute),
    .output_two_mute(output_two_mute));

// ### dv/scr_regs_tb.sv
// Self-checking testbench for the configuration register slice
`timescale 1ns/1ps
module scr_regs_tb;
    import scr_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, ref_tick = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, dbuf_update = 1'b0, cal_start = 1'b0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata_ff;
    logic [1:0]  od = '0, core = '0, od_q, core_q;
    logic [7:0]  rdv = '0, fdv = '0, band = '0, dly = '0, rd_q, fd_q, band_q, dly_q;
    logic [5:0]  bias = '0, bias_q;
    logic        busy, gen, lut_mode, decide, done, lvl, conv, adc_clk, adc_tick;
    logic [2:0]  m1, m2;
    wire  [41:0] q_all = {od_q, rd_q, fd_q, core_q, band_q, bias_q, dly_q};
    int          failures = 0;
    int          num_checks = 0;

    scr_regs #(.SEARCH_STEPS(2)) u_dut (
        .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .dbuf_update(dbuf_update), .rf_output_divider(od), .digital_ref_clk_divider(rdv),
        .digital_fb_clk_divider(fdv), .manual_osc_core(core), .manual_osc_band(band),
        .manual_osc_bias(bias), .delay_ctrl(dly), .rf_output_divider_ff(od_q),
        .digital_ref_clk_divider_ff(rd_q), .digital_fb_clk_divider_ff(fd_q),
        .manual_osc_core_ff(core_q), .manual_osc_band_ff(band_q), .manual_osc_bias_ff(bias_q),
        .delay_ctrl_ff(dly_q), .ref_tick(ref_tick), .cal_start(cal_start),
        .calibration_busy(busy), .table_generate_active(gen), .table_lookup_mode(lut_mode),
        .cal_decide_ff(decide), .cal_done_ff(done), .output_one_mute(m1),
        .output_two_mute(m2), .logic_level_high(lvl), .conversion_enable(conv),
        .adc_clk(adc_clk), .adc_tick(adc_tick));

    always #2.5 clk = ~clk;

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), e, reg_rdata_ff);
    endtask

    task automatic run_cal(input int exp_n, input int exp_d, input logic [1:0] exp_mode);
        int n;
        int d;
        d = 0;
        @(posedge clk);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        #1;
        chk("table modes", exp_mode, {gen, lut_mode});
        rd(SCR_STATUS_OFFS, exp_mode[1] ? 8'h82 : 8'h02);
        // Two edges of the busy time went to the status read
        n = 2;
        while (busy === 1'b1 && n < 3000) begin
            n++;
            @(posedge clk);
            #1;
            d += (decide === 1'b1);
        end
        chk("busy cycles", exp_n, n);
        chk("decision steps", exp_d, d);
        chk("done pulse", 1'b1, done);
    endtask

    task automatic adc_per(input logic [7:0] div);
        int n;
        wr(12'h03e, div);
        wr(12'h03f, 8'h02);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (adc_tick !== 1'b1 && n < 2000);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (adc_tick !== 1'b1 && n < 2000);
        chk("adc clock period", 4 * div + 2, n);
        chk("adc clock level", 1'b1, adc_clk);
        wr(12'h03f, 8'h00);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        final_report;
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < SCR_REG_NUM; i++) begin
            rd(SCR_OFFS[i], SCR_RESET_VAL);
        end
        rd(SCR_STATUS_OFFS, 8'h00);
        for (int i = 0; i < SCR_REG_NUM; i++) begin
            wr(SCR_OFFS[i], 8'h5a ^ 8'(i));
        end
        for (int i = 0; i < SCR_REG_NUM; i++) begin
            rd(SCR_OFFS[i], 8'h5a ^ 8'(i));
        end
        wr(12'h047, 8'hff);
        rd(12'h047, 8'h00);
        wr(SCR_STATUS_OFFS, 8'hff);
        rd(SCR_STATUS_OFFS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(12'h040, {2'b00, 3'(7 - i), 3'(i)});
            #1;
            chk("output one mute", i, m1);
            chk("output two mute", 7 - i, m2);
        end
        wr(12'h03d, 8'h20);
        wr(12'h03f, 8'h80);
        #1;
        chk("level and conversion", 2'b11, {lvl, conv});
        // Buffered: raw changes must wait for the update pulse
        wr(12'h036, 8'hc0);
        wr(12'h039, 8'h80);
        wr(12'h03b, 8'h80);
        {od, rdv, fdv, core, band, bias, dly} <= 42'h214_313c_557e;
        repeat (3) @(posedge clk);
        #1;
        chk("held applied values", 42'h0, q_all);
        @(posedge clk);
        dbuf_update <= 1'b1;
        @(posedge clk);
        dbuf_update <= 1'b0;
        #1;
        chk("updated applied values", 42'h214_313c_557e, q_all);
        wr(12'h036, 8'h00);
        wr(12'h039, 8'h00);
        wr(12'h03b, 8'h00);
        {od, rdv, fdv, core, band, bias, dly} <= 42'h1e2_a9b1_e3c4;
        repeat (2) @(posedge clk);
        #1;
        chk("direct applied values", 42'h1e2_a9b1_e3c4, q_all);
        wr(12'h038, 8'h00);
        wr(12'h039, 8'h01);
        wr(12'h03a, 8'h02);
        wr(12'h03b, 8'h01);
        wr(12'h037, 8'h03);
        wr(12'h036, 8'h02);
        run_cal(524, 2, 2'b10);
        wr(12'h036, 8'h01);
        run_cal(520, 1, 2'b01);
        adc_per(8'h00);
        adc_per(8'h02);
        final_report;
    end
endmodule // scr_regs_tb
